/* core/tcmp_cfg.svh */
// register offsets, field positions and reset values of the triple comparator block
// assumes a 32-bit apb slave with one register per aligned word
`ifndef TCMP_CFG_SVH
`define TCMP_CFG_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define TCMP_OFS_CH1        12'h000
`define TCMP_OFS_CH2        12'h004
`define TCMP_OFS_CH3        12'h008
`define TCMP_OFS_STAT       12'h00C
`define TCMP_OFS_LADDER     12'h010

// ----------------------------------------
// channel control fields
// ----------------------------------------
`define TCMP_CH_ON          15
`define TCMP_CH_PIN         14
`define TCMP_CH_INV         13
`define TCMP_CH_EVT         9
`define TCMP_CH_RES         8
`define TCMP_CH_EDGE_HI     7
`define TCMP_CH_EDGE_LO     6
`define TCMP_CH_POS         4
`define TCMP_CH_NEG_HI      1
`define TCMP_CH_NEG_LO      0
`define TCMP_CH_WMASK       16'hE0D3

// ----------------------------------------
// status and ladder fields
// ----------------------------------------
`define TCMP_ST_IDLE        15
`define TCMP_ST_EVT_LO      8
`define TCMP_ST_RES_LO      0
`define TCMP_LD_POWER       7
`define TCMP_LD_PIN         6
`define TCMP_LD_RANGE       5
`define TCMP_LD_SOURCE      4
`define TCMP_LD_WMASK       16'h00FF

// ----------------------------------------
// reset values
// ----------------------------------------
`define TCMP_RST_CH         16'h0000
`define TCMP_RST_LADDER     8'h00
`define TCMP_RST_IDLE       1'b0

`endif

/* core/tcmp_pkg.sv */
// types shared by the triple comparator block
// assumes tcmp_cfg.svh for the numbers
package tcmp_pkg;
   typedef enum logic [1:0] {TCMP_EV_OFF, TCMP_EV_RISE, TCMP_EV_FALL, TCMP_EV_ANY} tcmp_edge_t;
   typedef enum logic [1:0] {TCMP_NEG_B, TCMP_NEG_C, TCMP_NEG_D, TCMP_NEG_HALF_BG} tcmp_neg_t;
endpackage

/* core/tcmp_sync.sv */
// two-flop synchroniser for one level from the analog side
// assumes a free-running clk_in
`timescale 1ns/1ps
`default_nettype none
module tcmp_sync
(
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rst_in,
   // level
   input  wire logic d_in,
   output logic      q_out
);
   typedef struct packed
   {
      logic first;
      logic second;
   } tcmp_sync_state_t;

   tcmp_sync_state_t st;
   tcmp_sync_state_t next_st;

   always_comb
   begin
      next_st.first = d_in;
      next_st.second = st.first;
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         st <= '0;
      else
         st <= next_st;
   end

   assign q_out = st.second;
endmodule
`default_nettype wire

/* core/tcmp_channel.sv */
// one comparator channel: input synchronisation, polarity, pin drive and event latch
// assumes the raw analog result arrives unsynchronised on raw_in
`timescale 1ns/1ps
`default_nettype none
module tcmp_channel
   import tcmp_pkg::*;
(
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   // configuration
   input  wire logic       on_in,
   input  wire logic       invert_in,
   input  wire logic       pin_en_in,
   input  wire logic [1:0] edge_sel_in,
   input  wire logic       flag_clear_in,
   // analog core
   input  wire logic       raw_in,
   // results
   output logic            result_out,
   output logic            pin_out,
   output logic            pin_oe_out,
   output logic            flag_out,
   output logic            trig_out
);
   typedef struct packed
   {
      logic result;
      logic flag;
      logic trig;
   } tcmp_ch_state_t;

   tcmp_ch_state_t st;
   tcmp_ch_state_t next_st;
   logic           raw_sync;
   logic           adj;
   logic           hit;

   tcmp_sync u_sync
   (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .d_in   (raw_in),
      .q_out  (raw_sync)
   );

   assign adj = on_in & (raw_sync ^ invert_in);

   always_comb
   begin
      case (tcmp_edge_t'(edge_sel_in))
         TCMP_EV_RISE: hit = adj & ~st.result;
         TCMP_EV_FALL: hit = ~adj & st.result;
         TCMP_EV_ANY:  hit = adj ^ st.result;
         default:      hit = 1'b0;
      endcase
      next_st.result = adj;
      next_st.trig = hit & on_in & ~st.flag;
      // set wins over a clear in the same cycle
      next_st.flag = (st.flag & ~flag_clear_in) | (hit & on_in);
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
         st <= '0;
      else
         st <= next_st;
   end

   // pin path stays unsynchronised on purpose
   assign pin_out    = on_in & (raw_in ^ invert_in);
   assign pin_oe_out = on_in & pin_en_in;
   assign result_out = st.result;
   assign flag_out   = st.flag;
   assign trig_out   = st.trig;

   chk_flag_blocks_trig: assert property (@(posedge clk_in) disable iff (rst_in)
      st.flag |=> !st.trig) else $error("trigger while flag set");
   chk_off_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
      !on_in |=> !st.result) else $error("result active while off");
endmodule
`default_nettype wire

/* core/tcmp_top.sv */
// triple comparator and reference ladder control behind an apb slave
// assumes analog cores sample the select outputs and return raw results
`timescale 1ns/1ps
`default_nettype none
`include "tcmp_cfg.svh"

// How it works
// - three channels, each with own identical register
// - pin enable drives raw result to pin
// - bit 13 inverts result, pin and events
// - bit 4 picks ladder or pin A
// - bits 1-0 pick B, C, D, half bandgap
// - idle-stop bit blocks interrupts in idle
// - status bits 10-8 mirror event flags
// - status bits 2-0 mirror result bits
// - ladder has two ranges, sixteen levels
// - bit 5 picks ladder range
// - bit 4 picks ladder supply source
// - bit 6 connects ladder to pin while bit 7 powers it
// - range one: code over 24 of span
// - range zero: quarter plus code over 32
// - unimplemented bits read zero, ignore writes
module tcmp_top
   import tcmp_pkg::*;
(
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // apb
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic [3:0]  pstrb_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // device state
   input  wire logic        idle_mode_in,
   // analog comparator cores
   input  wire logic [2:0]  raw_result_in,
   output logic [2:0]       positive_input_select_out,
   output logic [5:0]       negative_input_select_out,
   // channel pins
   output logic [2:0]       channel_output_pin_out,
   output logic [2:0]       channel_output_pin_oe_out,
   // events
   output logic [2:0]       trigger_out,
   output logic             interrupt_out,
   // reference ladder
   output logic             ladder_power_on_out,
   output logic             ladder_pin_output_out,
   output logic             ladder_range_select_out,
   output logic             ladder_source_select_out,
   output logic [3:0]       ladder_level_code_out,
   output logic [5:0]       ladder_level_num_out,
   output logic [5:0]       ladder_level_den_out
);
   typedef struct packed
   {
      logic [2:0][15:0] ch;
      logic             idle_stop;
      logic [7:0]       ladder;
      logic [31:0]      rdata;
      logic             irq;
   } tcmp_state_t;

   tcmp_state_t st;
   tcmp_state_t next_st;
   logic [2:0]  result;
   logic [2:0]  flag;
   logic [2:0]  trig;
   logic [2:0]  clr;
   logic        wr;
   logic        rd;
   logic        mapped;
   logic [15:0] wdata;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                           input logic [3:0] strb, input logic [15:0] mask);
      logic [15:0] lanes;
      lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
      merge16 = (old & ~lanes) | (nw & lanes);
   endfunction

   function automatic logic [15:0] chan_view(input logic [15:0] c, input logic r,
                                             input logic f);
      chan_view = c & `TCMP_CH_WMASK;
      chan_view[`TCMP_CH_EVT] = f;
      chan_view[`TCMP_CH_RES] = r;
   endfunction

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   assign wr     = psel_in & penable_in & pwrite_in;
   assign rd     = psel_in & ~penable_in & ~pwrite_in;
   assign wdata  = pwdata_in[15:0];
   assign mapped = (paddr_in == `TCMP_OFS_CH1) || (paddr_in == `TCMP_OFS_CH2) ||
                   (paddr_in == `TCMP_OFS_CH3) || (paddr_in == `TCMP_OFS_STAT) ||
                   (paddr_in == `TCMP_OFS_LADDER);

   // writing zero to an event flag clears it; writing one has no effect
   always_comb
   begin
      clr[0] = wr & (paddr_in == `TCMP_OFS_CH1) & pstrb_in[1] & ~wdata[`TCMP_CH_EVT];
      clr[1] = wr & (paddr_in == `TCMP_OFS_CH2) & pstrb_in[1] & ~wdata[`TCMP_CH_EVT];
      clr[2] = wr & (paddr_in == `TCMP_OFS_CH3) & pstrb_in[1] & ~wdata[`TCMP_CH_EVT];
   end

   // ----------------------------------------
   // channels
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1)
      begin : g_ch
         tcmp_channel u_ch
         (
            .clk_in        (clk_in),
            .rst_in        (rst_in),
            .on_in         (st.ch[gi][`TCMP_CH_ON]),
            .invert_in     (st.ch[gi][`TCMP_CH_INV]),
            .pin_en_in     (st.ch[gi][`TCMP_CH_PIN]),
            .edge_sel_in   (st.ch[gi][`TCMP_CH_EDGE_HI:`TCMP_CH_EDGE_LO]),
            .flag_clear_in (clr[gi]),
            .raw_in        (raw_result_in[gi]),
            .result_out    (result[gi]),
            .pin_out       (channel_output_pin_out[gi]),
            .pin_oe_out    (channel_output_pin_oe_out[gi]),
            .flag_out      (flag[gi]),
            .trig_out      (trig[gi])
         );
         assign positive_input_select_out[gi] = st.ch[gi][`TCMP_CH_POS];
         assign negative_input_select_out[2*gi+1:2*gi] =
            st.ch[gi][`TCMP_CH_NEG_HI:`TCMP_CH_NEG_LO];
      end
   endgenerate

   // ----------------------------------------
   // register file
   // ----------------------------------------
   always_comb
   begin
      next_st = st;
      if (wr)
      begin
         case (paddr_in)
            `TCMP_OFS_CH1:
               next_st.ch[0] = merge16(st.ch[0], wdata, pstrb_in, `TCMP_CH_WMASK);
            `TCMP_OFS_CH2:
               next_st.ch[1] = merge16(st.ch[1], wdata, pstrb_in, `TCMP_CH_WMASK);
            `TCMP_OFS_CH3:
               next_st.ch[2] = merge16(st.ch[2], wdata, pstrb_in, `TCMP_CH_WMASK);
            `TCMP_OFS_STAT:
               if (pstrb_in[1])
                  next_st.idle_stop = wdata[`TCMP_ST_IDLE];
            `TCMP_OFS_LADDER:
               if (pstrb_in[0])
                  next_st.ladder = wdata[7:0];
            default:
               next_st.ch = st.ch;
         endcase
      end
      next_st.rdata = 32'h0000_0000;
      if (rd)
      begin
         case (paddr_in)
            `TCMP_OFS_CH1:
               next_st.rdata[15:0] = chan_view(st.ch[0], result[0], flag[0]);
            `TCMP_OFS_CH2:
               next_st.rdata[15:0] = chan_view(st.ch[1], result[1], flag[1]);
            `TCMP_OFS_CH3:
               next_st.rdata[15:0] = chan_view(st.ch[2], result[2], flag[2]);
            `TCMP_OFS_STAT:
            begin
               next_st.rdata[`TCMP_ST_IDLE] = st.idle_stop;
               next_st.rdata[`TCMP_ST_EVT_LO+2:`TCMP_ST_EVT_LO] = flag;
               next_st.rdata[`TCMP_ST_RES_LO+2:`TCMP_ST_RES_LO] = result;
            end
            `TCMP_OFS_LADDER:
               next_st.rdata[7:0] = st.ladder;
            default:
               next_st.rdata = 32'h0000_0000;
         endcase
      end
      // interrupts gated in idle when asked, comparators keep running
      next_st.irq = (|trig) & ~(st.idle_stop & idle_mode_in);
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         st           <= '0;
         st.ch        <= {3{`TCMP_RST_CH}};
         st.ladder    <= `TCMP_RST_LADDER;
         st.idle_stop <= `TCMP_RST_IDLE;
      end
      else
         st <= next_st;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign prdata_out    = st.rdata;
   assign pready_out    = psel_in & penable_in;
   assign pslverr_out   = psel_in & penable_in & ~mapped;
   assign trigger_out   = trig;
   assign interrupt_out = st.irq;

   // ladder: the analog divider is told num/den of the span to output
   assign ladder_power_on_out      = st.ladder[`TCMP_LD_POWER];
   assign ladder_pin_output_out    = st.ladder[`TCMP_LD_PIN] & st.ladder[`TCMP_LD_POWER];
   assign ladder_range_select_out  = st.ladder[`TCMP_LD_RANGE];
   assign ladder_source_select_out = st.ladder[`TCMP_LD_SOURCE];
   assign ladder_level_code_out    = st.ladder[3:0];
   // range one: code/24; range zero: (8 + code)/32
   assign ladder_level_num_out = st.ladder[`TCMP_LD_RANGE] ?
                                 {2'b00, st.ladder[3:0]} :
                                 6'h08 + {2'b00, st.ladder[3:0]};
   assign ladder_level_den_out = st.ladder[`TCMP_LD_RANGE] ? 6'h18 : 6'h20;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   sequence s_idle_gate;
      st.idle_stop && idle_mode_in;
   endsequence

   chk_idle_gate_irq: assert property (@(posedge clk_in) disable iff (rst_in)
      s_idle_gate |=> !interrupt_out) else $error("interrupt in idle");
   chk_stat_mirror_evt: assert property (@(posedge clk_in) disable iff (rst_in)
      (rd && paddr_in == `TCMP_OFS_STAT) |=> prdata_out[10:8] == $past(flag))
      else $error("event mirror wrong");
   chk_stat_mirror_out: assert property (@(posedge clk_in) disable iff (rst_in)
      (rd && paddr_in == `TCMP_OFS_STAT) |=> prdata_out[2:0] == $past(result))
      else $error("result mirror wrong");
   chk_ladder_range_hi: assert property (@(posedge clk_in) disable iff (rst_in)
      st.ladder[5] |-> ladder_level_den_out == 6'h18 && ladder_level_num_out <= 6'h0F)
      else $error("range one ratio wrong");
   chk_ladder_range_lo: assert property (@(posedge clk_in) disable iff (rst_in)
      !st.ladder[5] |-> ladder_level_den_out == 6'h20 && ladder_level_num_out >= 6'h08)
      else $error("range zero ratio wrong");
   chk_unimpl_zero: assert property (@(posedge clk_in) disable iff (rst_in)
      (rd && paddr_in == `TCMP_OFS_LADDER) |=> prdata_out[31:8] == 24'h000000)
      else $error("unimplemented bits nonzero");
   chk_pin_oe_gate: assert property (@(posedge clk_in) disable iff (rst_in)
      channel_output_pin_oe_out[0] |-> st.ch[0][15] && st.ch[0][14])
      else $error("pin driven without enable");
   chk_pin_ladder: assert property (@(posedge clk_in) disable iff (rst_in)
      ladder_pin_output_out |-> st.ladder[6]) else $error("ladder pin wrong");

   // ----------------------------------------
   // write-through checks
   // ----------------------------------------
   sequence s_wr_ch1_lo;
      wr && paddr_in == `TCMP_OFS_CH1 && pstrb_in[0];
   endsequence

   sequence s_wr_ladder;
      wr && paddr_in == `TCMP_OFS_LADDER && pstrb_in[0];
   endsequence

   sequence s_irq_open;
      (|trigger_out) && !(st.idle_stop && idle_mode_in);
   endsequence

   chk_pos_sel_write: assert property (@(posedge clk_in) disable iff (rst_in)
      s_wr_ch1_lo |=> positive_input_select_out[0] == $past(pwdata_in[4]))
      else $error("positive select not applied");
   chk_neg_sel_write: assert property (@(posedge clk_in) disable iff (rst_in)
      s_wr_ch1_lo |=> negative_input_select_out[1:0] == $past(pwdata_in[1:0]))
      else $error("negative select not applied");
   chk_ladder_code_wr: assert property (@(posedge clk_in) disable iff (rst_in)
      s_wr_ladder |=> ladder_level_code_out == $past(pwdata_in[3:0]))
      else $error("ladder code not applied");
   chk_ladder_range_wr: assert property (@(posedge clk_in) disable iff (rst_in)
      s_wr_ladder |=> ladder_range_select_out == $past(pwdata_in[5]))
      else $error("ladder range not applied");
   chk_ladder_src_wr: assert property (@(posedge clk_in) disable iff (rst_in)
      s_wr_ladder |=> ladder_source_select_out == $past(pwdata_in[4]))
      else $error("ladder source not applied");
   chk_chan_unimpl: assert property (@(posedge clk_in) disable iff (rst_in)
      (rd && paddr_in == `TCMP_OFS_CH2) |=> (prdata_out & ~32'h0000_E3D3) == 32'h0000_0000)
      else $error("channel unimplemented bits nonzero");
   chk_stat_unimpl: assert property (@(posedge clk_in) disable iff (rst_in)
      (rd && paddr_in == `TCMP_OFS_STAT) |=> (prdata_out & ~32'h0000_8707) == 32'h0000_0000)
      else $error("status unimplemented bits nonzero");
   chk_irq_follows: assert property (@(posedge clk_in) disable iff (rst_in)
      s_irq_open |=> interrupt_out) else $error("interrupt missing after trigger");
   chk_ch3_off_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
      !st.ch[2][15] |-> !channel_output_pin_oe_out[2] && !channel_output_pin_out[2])
      else $error("channel three pin active while off");
   chk_ch2_oe_gate: assert property (@(posedge clk_in) disable iff (rst_in)
      channel_output_pin_oe_out[1] |-> st.ch[1][15] && st.ch[1][14])
      else $error("channel two pin driven without enable");
endmodule
`default_nettype wire

/* test/tcmp_analog_model.sv */
// behavioural model of the three analog comparator cores and the ladder
// assumes pin voltages in millivolts, shared by all three channels
`timescale 1ns/1ps
`default_nettype none
module tcmp_analog_model
#(
   parameter int SPAN_MV    = 3300,
   parameter int HALF_BG_MV = 600
)
(
   // selects from the block
   input  wire logic [2:0]  pos_sel_in,
   input  wire logic [5:0]  neg_sel_in,
   input  wire logic        ladder_on_in,
   input  wire logic [5:0]  num_in,
   input  wire logic [5:0]  den_in,
   // pin voltages
   input  wire logic [11:0] a_mv_in,
   input  wire logic [11:0] b_mv_in,
   input  wire logic [11:0] c_mv_in,
   input  wire logic [11:0] d_mv_in,
   // raw results
   output logic [2:0]       raw_out
);
   int ladder_mv;
   int pos_mv;
   int neg_mv;

   always_comb
   begin
      // an unpowered ladder gives nothing, so a mis-gated select shows up
      ladder_mv = (ladder_on_in && den_in != 6'h00) ? SPAN_MV * num_in / den_in : 0;
      for (int i = 0; i < 3; i++)
      begin
         pos_mv = pos_sel_in[i] ? ladder_mv : int'(a_mv_in);
         case (neg_sel_in[2*i +: 2])
            2'h0:    neg_mv = int'(b_mv_in);
            2'h1:    neg_mv = int'(c_mv_in);
            2'h2:    neg_mv = int'(d_mv_in);
            default: neg_mv = HALF_BG_MV;
         endcase
         raw_out[i] = pos_mv > neg_mv;
      end
   end
endmodule
`default_nettype wire

/* test/tcmp_top_bench.sv */
// self-checking bench for the triple comparator block over apb
// assumes zero-wait apb answers and a three-edge event latency
`timescale 1ns/1ps
`default_nettype none
`include "tcmp_cfg.svh"
module tcmp_top_bench
   import tcmp_pkg::*;
;
   logic clk_in = 0, rst_in = 1, psel = 0, penable = 0, pwrite = 0, idle = 0;
   logic [11:0] paddr = 12'h000, a_mv = 12'h1F4, b_mv = 12'h3E8, c_mv = 12'h7D0, d_mv = 12'hBB8;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [2:0]  raw, pos_sel, pin, pin_oe, trig;
   logic [5:0]  neg_sel, num, den;
   logic [3:0]  code;
   logic        pready, pslverr, irq, l_on, l_pin, l_rng, l_src, err;
   int n_errors = 0, comparisons = 0, ntrig = 0, nirq = 0, t0, i0;
   int exp_tr [4] = '{0, 2, 1, 2};

   always #10 clk_in = ~clk_in;
   always @(posedge clk_in)
   begin
      ntrig += (trig[0] === 1'b1);
      nirq  += (irq === 1'b1);
   end

   tcmp_top tcmp_top_inst (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .pstrb_in(4'h3), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .idle_mode_in(idle), .raw_result_in(raw), .positive_input_select_out(pos_sel),
      .negative_input_select_out(neg_sel), .channel_output_pin_out(pin),
      .channel_output_pin_oe_out(pin_oe), .trigger_out(trig), .interrupt_out(irq),
      .ladder_power_on_out(l_on), .ladder_pin_output_out(l_pin),
      .ladder_range_select_out(l_rng), .ladder_source_select_out(l_src),
      .ladder_level_code_out(code), .ladder_level_num_out(num), .ladder_level_den_out(den));

   tcmp_analog_model tcmp_analog_model_inst (.pos_sel_in(pos_sel), .neg_sel_in(neg_sel),
      .ladder_on_in(l_on), .num_in(num), .den_in(den), .a_mv_in(a_mv), .b_mv_in(b_mv),
      .c_mv_in(c_mv), .d_mv_in(d_mv), .raw_out(raw));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // data is taken at the completing rising edge, before the registers
   // update there; one idle edge follows so strobes never toggle twice
   task apb(input logic w, input logic [11:0] a, input logic [15:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {16'h0000, d};
      @(posedge clk_in);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
         n_errors++;
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_in);
   endtask

   task rchk(input logic [11:0] a, input logic [15:0] exp);
      apb(1'b0, a, 16'h0000);
      chk(rd, {16'h0000, exp});
   endtask

   task wait_cy(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   task wrap_up;
      $display("checks %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      #(20 * 5000);
      n_errors++;
      wrap_up;
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      wait_cy(16);
      rst_in <= 1'b0;
      wait_cy(1);
      // reset values, access kinds, unmapped place
      for (int k = 0; k < 5; k++)
         rchk(12'(4 * k), 16'h0000);
      for (int k = 0; k < 3; k++)
      begin
         apb(1'b1, 12'(4 * k), 16'h7FFF);
         rchk(12'(4 * k), 16'h60D3);
      end
      apb(1'b1, `TCMP_OFS_STAT, 16'hFFFF);
      rchk(`TCMP_OFS_STAT, 16'h8000);
      apb(1'b1, `TCMP_OFS_LADDER, 16'hFFFF);
      rchk(`TCMP_OFS_LADDER, 16'h00FF);
      apb(1'b0, 12'h020, 16'h0000);
      chk({rd[30:0], err}, 32'h1);
      $display("test registers done");
      // selects and ladder fractions
      for (int k = 0; k < 4; k++)
      begin
         apb(1'b1, `TCMP_OFS_CH2, 16'(k));
         chk({pos_sel, neg_sel}, {3'h5, 2'h3, 2'(k), 2'h3});
      end
      apb(1'b1, `TCMP_OFS_LADDER, 16'h00BF);
      chk({l_on, l_pin, l_rng, l_src, code, num, den}, {8'hBF, 6'd15, 6'd24});
      apb(1'b1, `TCMP_OFS_LADDER, 16'h00D0);
      chk({l_on, l_pin, l_rng, l_src, code, num, den}, {8'hD0, 6'd8, 6'd32});
      apb(1'b1, `TCMP_OFS_LADDER, 16'h00C8);
      chk({l_pin, num}, {1'b1, 6'd16});
      $display("test selects done");
      // ladder versus pin B at 1000 mV: 8/24 of 3300 wins, 7/24 loses
      apb(1'b1, `TCMP_OFS_LADDER, 16'h00A8);
      apb(1'b1, `TCMP_OFS_CH1, 16'h8010);
      wait_cy(6);
      rchk(`TCMP_OFS_STAT, 16'h8001);
      apb(1'b1, `TCMP_OFS_LADDER, 16'h00A7);
      wait_cy(6);
      rchk(`TCMP_OFS_STAT, 16'h8000);
      $display("test ladder done");
      // each event mode: two toggles, a clear, one more rise
      apb(1'b1, `TCMP_OFS_STAT, 16'h0000);
      for (int m = 0; m < 4; m++)
      begin
         apb(1'b1, `TCMP_OFS_CH1, 16'(16'h8000 | (m << 6)));
         wait_cy(8);
         t0 = ntrig;
         i0 = nirq;
         a_mv <= 12'h5DC;
         wait_cy(8);
         a_mv <= 12'h1F4;
         wait_cy(8);
         chk(32'(ntrig - t0), (m == 0) ? 0 : 1);
         rchk(`TCMP_OFS_STAT, (m == 0) ? 16'h0000 : 16'h0100);
         apb(1'b1, `TCMP_OFS_CH1, 16'(16'h8000 | (m << 6)));
         a_mv <= 12'h5DC;
         wait_cy(8);
         chk(32'(ntrig - t0), 32'(exp_tr[m]));
         chk(32'(nirq - i0), 32'(exp_tr[m]));
         a_mv <= 12'h1F4;
         wait_cy(8);
      end
      $display("test events done");
      // pin path, inversion and idle-time interrupt gating
      apb(1'b1, `TCMP_OFS_CH1, 16'hE040);
      a_mv <= 12'h5DC;
      wait_cy(1);
      chk({pin[0], pin_oe[0]}, 2'b01);
      wait_cy(8);
      rchk(`TCMP_OFS_STAT, 16'h0100);
      a_mv <= 12'h1F4;
      wait_cy(1);
      chk({pin[0], pin_oe[0]}, 2'b11);
      apb(1'b1, `TCMP_OFS_STAT, 16'h8000);
      apb(1'b1, `TCMP_OFS_CH1, 16'h8040);
      idle <= 1'b1;
      t0 = ntrig;
      i0 = nirq;
      a_mv <= 12'h5DC;
      wait_cy(8);
      chk(32'(ntrig - t0), 32'd1);
      chk(32'(nirq - i0), 32'd0);
      apb(1'b1, `TCMP_OFS_CH1, 16'h0040);
      a_mv <= 12'h1F4;
      wait_cy(8);
      chk({pin[0], pin_oe[0], 30'(ntrig - t0)}, 32'h1);
      $display("test pins and idle done");
      wrap_up;
   end
endmodule
`default_nettype wire
